/* rtl/ssp_map.svh */
// Register offsets, field positions, reset values and clock counts
// for the synchronous serial port. Included by bare name.
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SSP_OFS_BUF   6'h00
`define SSP_OFS_CON1  6'h04
`define SSP_OFS_STAT  6'h08
`define SSP_OFS_ADDR  6'h0C
`define SSP_OFS_CON2  6'h10
`define SSP_OFS_IRQF  6'h14
`define SSP_OFS_IRQE  6'h18
`define SSP_OFS_IRQP  6'h1C
`define SSP_OFS_AUX   6'h20

// ****************************************
// Field positions and values
// ****************************************
`define SSP_IRQ_BIT   3
`define SSP_RXONLY    0
`define SSP_GCALL     7
`define SSP_STAT_WMSK 8'hC0
`define SSP_M_SLV_SS  4'h4
`define SSP_M_SLV_NSS 4'h5
`define SSP_M_I2C_M   4'h8
`define SSP_M_I2C_FW  4'hB
`define SSP_ADDR10    5'h1E
`define SSP_RST_BYTE  8'h00

// ****************************************
// Master half-period counts in clk cycles
// ****************************************
`define SSP_HALF_DIV4  8'h02
`define SSP_HALF_DIV16 8'h08
`define SSP_HALF_DIV64 8'h20

`endif

/* rtl/ssp_pkg.sv */
// Types shared by the synchronous serial port files.
// Assumes nothing of its surroundings.
package ssp_pkg;

  // ****************************************
  // Control register one layout
  // ****************************************
  typedef struct packed {
    logic       write_collision_flag;   // Write collision
    logic       ovf;    // Receive overflow
    logic       en;     // Port enable
    logic       clock_idle_polarity;    // Clock idle polarity
    logic [3:0] mode;   // Port mode field
  } ssp_ctl_type;

  // ****************************************
  // Status register layout
  // ****************************************
  typedef struct packed {
    logic input_sample_phase;    // Sample phase / slew off
    logic cke;    // Clock edge / smbus levels
    logic d_a;    // Data (1) or address (0)
    logic stop;   // Stop seen last
    logic start;  // Start seen last
    logic rw;     // Read/write of last address
    logic ua;     // Update address
    logic bf;     // Receive buffer full
  } ssp_sta_type;

endpackage : ssp_pkg

/* rtl/ssp_shift.sv */
// Eight-bit shift engine with bit counter, MSB first.
// Assumes sample and drive strobes are one-cycle pulses on clk_i.
`timescale 1ns/100ps

module ssp_shift #(
  parameter int WIDTH = 8                 // Bits per byte
) (
  input  wire logic             clk_i,    // Device clock
  input  wire logic             rst_i,    // Sync reset, high
  input  wire logic             clear_i,  // Abort and zero count
  input  wire logic             load_i,   // Load new byte
  input  wire logic [WIDTH-1:0] data_i,   // Byte to load
  input  wire logic             sample_i, // Shift in one bit
  input  wire logic             drive_i,  // Present next bit
  input  wire logic             sdi_i,    // Serial data in
  output logic      [WIDTH-1:0] shreg_o,  // Shift register
  output logic      [2:0]       count_o,  // Bits taken so far
  output logic                  done_o,   // Byte complete pulse
  output logic                  sdo_o     // Bit on data out
);

  // ****************************************
  // Shift, count and output bit
  // ****************************************
  // Load wins over clear: a byte written while deselected must survive
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      shreg_o <= {WIDTH{1'b0}};
      count_o <= 3'h0;
      sdo_o   <= 1'b0;
    end else if (load_i) begin
      shreg_o <= data_i;
      sdo_o   <= data_i[WIDTH-1];
      count_o <= 3'h0;
    end else if (clear_i) begin
      // Abort drops the half byte; top bit stays ready on data out
      count_o <= 3'h0;
      sdo_o   <= shreg_o[WIDTH-1];
    end else begin
      // Drive edge shows the new top bit
      if (drive_i) begin
        sdo_o <= shreg_o[WIDTH-1];
      end
      if (sample_i) begin
        shreg_o <= {shreg_o[WIDTH-2:0], sdi_i};
        count_o <= count_o + 3'h1;
        done_o  <= (count_o == 3'(WIDTH - 1));
      end
    end
  end

endmodule : ssp_shift

/* rtl/ssp_port.sv */
// Synchronous serial port: SPI master/slave and I2C receive path
// behind a classic Wishbone slave. Assumes all pins are already
// synchronous to clk_i; the bench resolves the data pin from sdo_oe_o.
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`include "ssp_map.svh"

module ssp_port (
  input  wire logic        clk_i,          // Device clock
  input  wire logic        rst_i,          // Sync reset, high
  input  wire logic [5:0]  adr_i,          // Byte address
  input  wire logic [31:0] dat_i,          // Write data
  input  wire logic [3:0]  sel_i,          // Byte lanes
  input  wire logic        we_i,           // Write
  input  wire logic        cyc_i,          // Bus cycle
  input  wire logic        stb_i,          // Strobe
  output logic      [31:0] dat_o,          // Read data
  output logic             ack_o,          // Acknowledge
  input  wire logic        sleep_i,        // Device asleep
  input  wire logic        tmr_tick_i,     // Timer clock pulse
  input  wire logic        sck_i,          // Serial clock / SCL in
  input  wire logic        sdi_i,          // Serial data / SDA in
  input  wire logic        ss_n_i,         // Slave select, low
  output logic             sdo_o,          // Serial data out
  output logic             sdo_oe_o,       // Data out enable
  output logic             sck_o,          // Master clock out
  output logic             sck_oe_o,       // Clock out enable
  output logic      [6:0]  baud_reload_o,  // Rate reload value
  output logic             slew_off_o,     // Slew control off
  output logic             smbus_lvl_o,    // Bus input levels
  output logic             wake_o          // Wake request
);

  // ****************************************
  // Registers
  // ****************************************
  ssp_pkg::ssp_ctl_type ctl_q;    // Control one
  ssp_pkg::ssp_sta_type sta_q;    // Status
  logic [7:0] buf_q;              // Transmit/receive buffer
  logic [7:0] addr_q;             // Address / baud register
  logic [7:0] con2_q;             // Control two
  logic [7:0] irqf_q;             // Irq flags
  logic [7:0] irqe_q;             // Irq enables
  logic [7:0] irqp_q;             // Irq priorities
  logic [7:0] aux_q;              // Pin options
  logic       mst_run_q;          // Master transfer running
  logic [7:0] div_q;              // Master divider
  logic       sck_q;              // Master clock level
  logic       sck_p_q;            // Previous clock level
  logic       sda_p_q;            // Previous I2C data level
  logic       frame_q;            // Inside I2C frame
  logic       first_q;            // Next I2C byte is address
  logic       match_q;            // Address matched

  // ****************************************
  // Engine wires
  // ****************************************
  logic [7:0] shreg;              // Shift contents
  logic [2:0] bit_cnt;            // Bit counter
  logic       done;               // Byte complete
  logic       sdo_bit;            // Engine data bit

  // ****************************************
  // Mode decode
  // ****************************************
  wire [3:0] mode     = ctl_q.mode;
  wire       en       = ctl_q.en;
  wire       spi_mst  = en && (mode[3:2] == 2'b00);
  wire       ss_ctl   = en && (mode == `SSP_M_SLV_SS);
  wire       spi_slv  = ss_ctl || (en && (mode == `SSP_M_SLV_NSS));
  wire       i2c      = en && !spi_mst && !spi_slv;
  wire       i2c_mst  = (mode == `SSP_M_I2C_M) || (mode == `SSP_M_I2C_FW);
  wire       addr10   = mode[0];
  wire       ss_off   = ss_ctl && ss_n_i;
  wire       rx_only  = aux_q[`SSP_RXONLY];

  // ****************************************
  // Clock edge decode
  // ****************************************
  wire       sck_in   = spi_mst ? sck_q : sck_i;
  wire       rise     = sck_in && !sck_p_q;
  wire       fall     = !sck_in && sck_p_q;
  wire       act_e    = ctl_q.clock_idle_polarity ? fall : rise;
  wire       idle_e   = ctl_q.clock_idle_polarity ? rise : fall;
  // select low lets the slave shift; sleep parks the master
  wire       spi_go   = (mst_run_q && !sleep_i) || (spi_slv && !ss_off);
  wire       spi_smp  = spi_go && (sta_q.cke ? act_e : idle_e);
  wire       spi_drv  = spi_go && (sta_q.cke ? idle_e : act_e);

  // ****************************************
  // I2C conditions, sampled while SCL high
  // ****************************************
  wire       start_e  = i2c && sck_i && sck_p_q && sda_p_q && !sdi_i;
  wire       stop_e   = i2c && sck_i && sck_p_q && !sda_p_q && sdi_i;
  wire       i2c_smp  = i2c && frame_q && rise;
  wire       ss_irq   = mode[3] && mode[2] && (start_e || stop_e);
  // own address, general call or 10-bit header
  wire       own_hit  = addr10 ? (shreg[7:3] == `SSP_ADDR10)
                                : (shreg[7:1] == addr_q[7:1]);
  wire       gcall    = con2_q[`SSP_GCALL] && (shreg == `SSP_RST_BYTE);
  wire       i2c_keep = i2c_mst || (first_q ? (own_hit || gcall) : match_q);

  // ****************************************
  // Bus decode
  // ****************************************
  wire       req      = cyc_i && stb_i;
  wire       fire     = req && ack_o;
  wire       wr       = fire && we_i && sel_i[0];
  wire       rd       = fire && !we_i;
  wire       wr_buf   = wr && (adr_i == `SSP_OFS_BUF);
  wire       wr_con1  = wr && (adr_i == `SSP_OFS_CON1);
  wire       wr_stat  = wr && (adr_i == `SSP_OFS_STAT);
  wire       wr_irqf  = wr && (adr_i == `SSP_OFS_IRQF);
  wire       rd_buf   = rd && (adr_i == `SSP_OFS_BUF);
  wire [7:0] wbyte    = dat_i[7:0];
  wire       busy     = mst_run_q || (bit_cnt != 3'h0);
  wire       buf_ok   = wr_buf && !busy;
  wire       collide  = wr_buf && busy;
  wire       got_byte = done && (spi_mst || spi_slv || i2c_keep);
  wire       ovf_hit  = got_byte && sta_q.bf;
  // select high or disable clears the counter
  wire       eng_clr  = !en || ss_off || start_e || stop_e;

  // ****************************************
  // Read data mux
  // ****************************************
  logic [7:0] rdata;
  always_comb begin
    unique case (adr_i)
      `SSP_OFS_BUF:  rdata = buf_q;
      `SSP_OFS_CON1: rdata = ctl_q;
      `SSP_OFS_STAT: rdata = sta_q;
      `SSP_OFS_ADDR: rdata = addr_q;
      `SSP_OFS_CON2: rdata = con2_q;
      `SSP_OFS_IRQF: rdata = irqf_q;
      `SSP_OFS_IRQE: rdata = irqe_q;
      `SSP_OFS_IRQP: rdata = irqp_q;
      `SSP_OFS_AUX:  rdata = aux_q;
      default:       rdata = 8'h00;
    endcase
  end

  // ****************************************
  // Shift engine
  // ****************************************
  // accepted write loads shift and buffer together
  ssp_shift #(
    .WIDTH (8)
  ) u_shift (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (eng_clr),
    .load_i   (buf_ok),
    .data_i   (wbyte),
    .sample_i (spi_smp || i2c_smp),
    .drive_i  (spi_drv),
    .sdi_i    (sdi_i),
    .shreg_o  (shreg),
    .count_o  (bit_cnt),
    .done_o   (done),
    .sdo_o    (sdo_bit)
  );

  // ****************************************
  // Wishbone answer, one cycle after request
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req && !ack_o;
      dat_o <= {24'h00_0000, rdata};
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  // reset leaves the port disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= `SSP_RST_BYTE;
      con2_q <= `SSP_RST_BYTE;
      irqe_q <= `SSP_RST_BYTE;
      irqp_q <= `SSP_RST_BYTE;
      aux_q  <= `SSP_RST_BYTE;
    end else if (wr) begin
      if (adr_i == `SSP_OFS_ADDR) addr_q <= wbyte;
      if (adr_i == `SSP_OFS_CON2) con2_q <= wbyte;
      if (adr_i == `SSP_OFS_IRQE) irqe_q <= wbyte;
      if (adr_i == `SSP_OFS_IRQP) irqp_q <= wbyte;
      if (adr_i == `SSP_OFS_AUX)  aux_q  <= wbyte;
    end
  end

  // ****************************************
  // Control one; hardware sets win
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= `SSP_RST_BYTE;
    end else begin
      if (wr_con1) ctl_q <= wbyte;
      if (collide) ctl_q.write_collision_flag <= 1'b1;
      if (ovf_hit) ctl_q.ovf  <= 1'b1;
    end
  end

  // ****************************************
  // Buffer and irq flag
  // ****************************************
  // finished byte moves in, flag set
  // an unread byte is kept and overflow reported instead
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_q  <= `SSP_RST_BYTE;
      irqf_q <= `SSP_RST_BYTE;
    end else begin
      if (buf_ok) buf_q <= wbyte;
      if (got_byte && !sta_q.bf) buf_q <= shreg;
      if (wr_irqf) irqf_q <= wbyte;
      if (got_byte || ss_irq) irqf_q[`SSP_IRQ_BIT] <= 1'b1;
    end
  end

  // ****************************************
  // Status register
  // ****************************************
  // only the top two bits take writes
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      sta_q <= `SSP_RST_BYTE;
      if (!rst_i) sta_q[7:6] <= sta_q[7:6];
    end else begin
      if (wr_stat) begin
        sta_q[7:6] <= wbyte[7:6];
      end
      if (rd_buf) sta_q.bf <= 1'b0;
      if (got_byte) sta_q.bf <= 1'b1;
      if (start_e) begin
        sta_q.start <= 1'b1;
        sta_q.stop  <= 1'b0;
      end
      if (stop_e) begin
        sta_q.start <= 1'b0;
        sta_q.stop  <= 1'b1;
      end
      // address or data; left alone in master
      if (i2c && !i2c_mst && got_byte) begin
        sta_q.d_a <= !first_q;
        if (first_q) sta_q.rw <= shreg[0];
        if (first_q) sta_q.ua <= addr10;
      end
    end
  end

  // ****************************************
  // I2C frame tracking
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || !i2c) begin
      frame_q <= 1'b0;
      first_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      if (start_e) begin
        frame_q <= 1'b1;
        first_q <= 1'b1;
        match_q <= 1'b0;
      end else if (stop_e) begin
        frame_q <= 1'b0;
      end else if (done) begin
        first_q <= 1'b0;
        if (first_q) match_q <= own_hit || gcall;
      end
    end
  end

  // ****************************************
  // Master clock generator
  // ****************************************
  // Divider only counts while running and awake
  logic [7:0] half;
  always_comb begin
    unique case (mode[1:0])
      2'b00:   half = `SSP_HALF_DIV4;
      2'b01:   half = `SSP_HALF_DIV16;
      2'b10:   half = `SSP_HALF_DIV64;
      default: half = 8'hFF;
    endcase
  end
  wire div_end = (mode[1:0] == 2'b11) ? tmr_tick_i
                                      : (div_q == half - 8'h01);

  always_ff @(posedge clk_i) begin
    if (rst_i || !spi_mst) begin
      mst_run_q <= 1'b0;
      div_q     <= 8'h00;
      sck_q     <= 1'b0;
    end else if (!mst_run_q) begin
      mst_run_q <= buf_ok;
      div_q     <= 8'h00;
      sck_q     <= ctl_q.clock_idle_polarity;
    end else if (done) begin
      mst_run_q <= 1'b0;
    end else if (!sleep_i) begin
      // sleep holds the transfer where it is
      div_q <= div_end ? 8'h00 : div_q + 8'h01;
      if (div_end) sck_q <= !sck_q;
    end
  end

  // ****************************************
  // Edge history
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_p_q <= 1'b0;
      sda_p_q <= 1'b1;
    end else begin
      // Held in master sleep so an edge pending at entry is seen on wake-up
      sck_p_q <= (spi_mst && sleep_i) ? sck_p_q : sck_in;
      sda_p_q <= sdi_i;
    end
  end

  // ****************************************
  // Pin and side outputs
  // ****************************************
  // Enable lags the select by one clock; the bench must allow it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdo_oe_o      <= 1'b0;
      sck_o         <= 1'b0;
      sck_oe_o      <= 1'b0;
      baud_reload_o <= 7'h00;
      slew_off_o    <= 1'b0;
      smbus_lvl_o   <= 1'b0;
      wake_o        <= 1'b0;
    end else begin
      // drive as master, or as slave unless deselected in select mode; never when rx-only
      sdo_oe_o      <= (spi_mst || (spi_slv && !ss_off)) && !rx_only;
      sck_o         <= sck_q;
      sck_oe_o      <= spi_mst;
      baud_reload_o <= (i2c && i2c_mst) ? addr_q[6:0] : 7'h00;
      slew_off_o    <= i2c && sta_q.input_sample_phase;
      smbus_lvl_o   <= i2c && sta_q.cke;
      wake_o        <= irqf_q[`SSP_IRQ_BIT] && irqe_q[`SSP_IRQ_BIT];
    end
  end
  assign sdo_o = sdo_bit;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_byte_end;
    done && spi_slv && !sta_q.bf;
  endsequence

  property p_ss_reset;
    @(posedge clk_i) disable iff (rst_i) ss_off |=> bit_cnt == 3'h0;
  endproperty
  a_ss_reset: assert property (p_ss_reset)
    else $error("select high did not clear count");

  property p_ss_drive;
    @(posedge clk_i) disable iff (rst_i)
      ss_ctl && !ss_n_i && !rx_only |=> sdo_oe_o;
  endproperty
  a_ss_drive: assert property (p_ss_drive)
    else $error("selected slave not driving");

  property p_ss_float;
    @(posedge clk_i) disable iff (rst_i) ss_off |=> !sdo_oe_o;
  endproperty
  a_ss_float: assert property (p_ss_float)
    else $error("data out driven after select high");

  property p_dis_clear;
    @(posedge clk_i) disable iff (rst_i) !en |=> bit_cnt == 3'h0 && !mst_run_q;
  endproperty
  a_dis_clear: assert property (p_dis_clear)
    else $error("disable left count running");

  property p_rx_only;
    @(posedge clk_i) disable iff (rst_i) rx_only |=> !sdo_oe_o;
  endproperty
  a_rx_only: assert property (p_rx_only)
    else $error("rx-only port drove data out");

  property p_sleep;
    @(posedge clk_i) disable iff (rst_i)
      mst_run_q && sleep_i && !buf_ok && spi_mst |=> $stable(bit_cnt) && $stable(sck_q);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("master moved while asleep");

  property p_byte_flag;
    @(posedge clk_i) disable iff (rst_i)
      s_byte_end |=> irqf_q[`SSP_IRQ_BIT] && sta_q.bf && buf_q == $past(shreg);
  endproperty
  a_byte_flag: assert property (p_byte_flag)
    else $error("byte not moved to buffer");

  property p_wake;
    @(posedge clk_i) disable iff (rst_i)
      ##1 wake_o == $past(irqf_q[`SSP_IRQ_BIT] && irqe_q[`SSP_IRQ_BIT]);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake does not follow enabled flag");

  property p_write_collision_flag;
    @(posedge clk_i) disable iff (rst_i) collide |=> ctl_q.write_collision_flag && $stable(buf_q);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag)
    else $error("busy write not refused");

endmodule : ssp_port

/* tb/ssp_spi_master_model.sv */
// External SPI master that drives the port's slave pins.
// Assumes the bench calls its tasks from a process clocked by clk_i.
`timescale 1ns/100ps

module ssp_spi_master_model (
  input  wire logic clk_i,  // Device clock
  input  wire logic sdo_i,  // Data line from port
  output logic      sck_o,  // Serial clock to port
  output logic      sdi_o,  // Data to port
  output logic      ss_n_o  // Select, low
);
  // Idle: deselected, clock low
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    ss_n_o = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask : w

  // select always on; edges per polarity and edge bit
  // The line holds the wrong value on the edge that must not sample
  // The port's data line is taken just before the edge that samples it
  task automatic send(input logic [7:0] b, input int n, input logic clock_idle_polarity, input logic cke,
                      output logic [7:0] r);
    r = 8'h00;
    sck_o <= clock_idle_polarity;
    ss_n_o <= 1'b0;
    w(3);
    for (int i = 7; i > 7 - n; i--) begin
      sdi_o <= cke ? b[i] : ~b[i];
      w(2);
      if (cke) r[i] = sdo_i;
      sck_o <= ~clock_idle_polarity;
      w(2);
      sdi_o <= cke ? ~b[i] : b[i];
      w(2);
      if (!cke) r[i] = sdo_i;
      sck_o <= clock_idle_polarity;
      w(2);
    end
  endtask : send

  // Deselect; data line left at the inverse of its last level
  task automatic stop();
    ss_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    w(3);
  endtask : stop
endmodule : ssp_spi_master_model

/* tb/sync_serial_spi_ss_i2c_regs_tb.sv */
// Self-checking bench for the serial port over Wishbone.
// Assumes the SPI master model drives the slave pins.
`timescale 1ns/100ps
`include "ssp_map.svh"

module sync_serial_spi_ss_i2c_regs_tb;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, sdo_o, sdo_oe_o, sck_o, sck_oe_o;
  logic sck_i, sdi_i, ss_n_i, slew_off_o, smbus_lvl_o, wake_o;
  logic [5:0]  adr_i;     // Bus address
  logic [31:0] dat_i;     // Write data
  logic [31:0] dat_o;     // Read data
  logic [3:0]  sel_i;     // Byte lanes
  logic [6:0]  baud_reload_o;
  logic [7:0]  exq[$];    // Expected read bytes
  logic [7:0]  b;         // Random byte
  logic [7:0]  t, r;      // Byte sent by the port, byte seen by the master
  logic        sleep_i;   // Device asleep
  int          err_count, checked, cycles, rnd;
  wire         sdo_line = sdo_oe_o ? sdo_o : ~sdo_o;  // Released line shows the inverse

  ssp_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
    .ack_o(ack_o), .sleep_i(sleep_i), .tmr_tick_i(1'b0), .sck_i(sck_i), .sdi_i(sdi_i),
    .ss_n_i(ss_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .baud_reload_o(baud_reload_o), .slew_off_o(slew_off_o),
    .smbus_lvl_o(smbus_lvl_o), .wake_o(wake_o));
  ssp_spi_master_model mdl_u (.clk_i(clk_i), .sdo_i(sdo_line), .sck_o(sck_i), .sdi_o(sdi_i),
    .ss_n_o(ss_n_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // Classic single cycle; a read notes its expected byte first
  task automatic wb(input logic [5:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    if (!w) exq.push_back(d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    adr_i <= a;
    we_i <= w;
    dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    if (n != 2) chk(8'h00, 8'h01, "ack time");
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  // Read data taken at the acknowledging edge
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && cyc_i && !we_i) chk(dat_o[7:0], exq.pop_front(), "read");
    if (dat_o[31:8] !== 24'h000000 && ack_o === 1'b1) chk(8'h00, 8'h01, "high bits");
  end

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      chk(8'h00, 8'h01, "timeout");
      test_done();
    end
  end

  initial begin
    {we_i, cyc_i, stb_i, adr_i, dat_i, sleep_i} = '0;
    sel_i = 4'hF;
    rst_i = 1'b1;
    rnd = $urandom(32'hF9BC49E3);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(`SSP_OFS_CON1, 1'b0, 8'h00);
    wb(`SSP_OFS_STAT, 1'b0, 8'h00);
    for (int m = 0; m < 4; m++) begin
      b = 8'($urandom());
      t = 8'($urandom());
      wb(`SSP_OFS_CON1, 1'b1, {3'b001, m[1], 4'h4});
      wb(`SSP_OFS_STAT, 1'b1, {1'b0, ~m[0], 6'h00});
      wb(`SSP_OFS_BUF, 1'b1, t);
      mdl_u.send(b, 8, m[1], ~m[0], r);
      chk({7'h00, sdo_oe_o}, 8'h01, "drive");
      chk(r, t, "slave out");
      mdl_u.stop();
      wb(`SSP_OFS_IRQF, 1'b0, 8'h08);
      wb(`SSP_OFS_STAT, 1'b0, {1'b0, ~m[0], 6'h01});
      wb(`SSP_OFS_BUF, 1'b0, b);
      wb(`SSP_OFS_IRQF, 1'b1, 8'h00);
      $display("spi mode %0d done", m);
    end
    mdl_u.send(8'hA5, 4, 1'b1, 1'b0, r);
    wb(`SSP_OFS_BUF, 1'b1, 8'h77);
    wb(`SSP_OFS_CON1, 1'b0, 8'hB4);
    mdl_u.stop();
    chk({7'h00, sdo_oe_o}, 8'h00, "float");
    wb(`SSP_OFS_CON1, 1'b1, 8'h34);
    b = 8'($urandom());
    mdl_u.send(b, 8, 1'b1, 1'b0, r);
    mdl_u.stop();
    wb(`SSP_OFS_IRQE, 1'b1, 8'h08);
    repeat (3) @(posedge clk_i);
    chk({7'h00, wake_o}, 8'h01, "wake");
    wb(`SSP_OFS_BUF, 1'b0, b);
    wb(`SSP_OFS_IRQF, 1'b1, 8'h00);
    repeat (3) @(posedge clk_i);
    chk({7'h00, wake_o}, 8'h00, "no wake");
    $display("select and collision done");
    wb(`SSP_OFS_AUX, 1'b1, 8'h01);
    mdl_u.send(b, 8, 1'b1, 1'b0, r);
    chk({7'h00, sdo_oe_o}, 8'h00, "rx only");
    mdl_u.stop();
    wb(`SSP_OFS_BUF, 1'b0, b);
    wb(`SSP_OFS_AUX, 1'b1, 8'h00);
    wb(`SSP_OFS_CON1, 1'b1, 8'h28);
    wb(`SSP_OFS_ADDR, 1'b1, 8'hD5);
    wb(`SSP_OFS_STAT, 1'b1, 8'hFF);
    wb(`SSP_OFS_STAT, 1'b0, 8'hC0);
    repeat (2) @(posedge clk_i);
    chk({1'b0, baud_reload_o}, 8'h55, "reload");
    chk({6'h00, slew_off_o, smbus_lvl_o}, 8'h03, "levels");
    chk({6'h00, sdo_oe_o, sck_oe_o}, 8'h00, "i2c pins in");
    $display("i2c registers done");
    wb(`SSP_OFS_CON1, 1'b1, 8'h34);
    mdl_u.send(b, 3, 1'b1, 1'b0, r);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({7'h00, sdo_oe_o}, 8'h00, "reset float");
    wb(`SSP_OFS_CON1, 1'b0, 8'h00);
    mdl_u.stop();
    $display("reset done");
    // Master at the fastest rate, put to sleep right after the load
    b = {8{sdi_i}};
    wb(`SSP_OFS_CON1, 1'b1, 8'h20);
    wb(`SSP_OFS_BUF, 1'b1, 8'h3C);
    sleep_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    wb(`SSP_OFS_IRQF, 1'b0, 8'h00);
    chk({7'h00, sck_oe_o}, 8'h01, "master clock");
    sleep_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    wb(`SSP_OFS_IRQF, 1'b0, 8'h08);
    wb(`SSP_OFS_BUF, 1'b0, b);
    $display("master sleep done");
    test_done();
  end
endmodule : sync_serial_spi_ss_i2c_regs_tb
